// file: hdl/sram_wmask_pkg.sv
// Constants, types and lane decoding for the burst SRAM write masking block
package sram_wmask_pkg;
	localparam int DATA_W = 36;
	localparam int ADDR_W = 6;
	localparam int LANES = 4;
	localparam int NIB_W = 4;
	localparam int LANE_W = 9;
	localparam int MEM_DEPTH = 64;
	localparam int FIFO_DEPTH = 16;
	localparam int ENTRY_W = ADDR_W + 2 * DATA_W;
	localparam int PIN_W = 6 + ADDR_W + DATA_W + LANES;
	localparam logic [DATA_W-1:0] MASK_NONE = 36'h0_0000_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;

	typedef enum logic [1:0] {ORG_X8, ORG_X9, ORG_X18, ORG_X36} org_e;
	localparam org_e ORG_RESET = ORG_X36;

	typedef enum logic [2:0] {ST_IDLE, ST_BEAT0, ST_BEAT1, ST_BEAT2, ST_BEAT3} wr_state_e;

	// Expands active-low lane selects into a per-bit write mask
	function automatic logic [DATA_W-1:0] lane_mask(input org_e org, input logic [LANES-1:0] sel_n);
		logic [DATA_W-1:0] m;
		m = MASK_NONE;
		case (org)
			ORG_X8: begin
				m[NIB_W-1:0] = {NIB_W{~sel_n[0]}};
				m[2*NIB_W-1:NIB_W] = {NIB_W{~sel_n[1]}};
			end
			ORG_X9: begin
				m[LANE_W-1:0] = {LANE_W{~sel_n[0]}};
			end
			ORG_X18: begin
				m[LANE_W-1:0] = {LANE_W{~sel_n[0]}};
				m[2*LANE_W-1:LANE_W] = {LANE_W{~sel_n[1]}};
			end
			default: begin
				for (int i = 0; i < LANES; i++) begin
					m[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
				end
			end
		endcase
		return m;
	endfunction

	// Narrow parts start the burst at 00, wide parts count linearly from the given low bits
	function automatic logic [ADDR_W-1:0] burst_index(input org_e org, input logic [ADDR_W-1:0] a,
			input logic [1:0] beat);
		logic [1:0] low;
		low = (org == ORG_X8 || org == ORG_X9) ? beat : a[1:0] + beat;
		return {a[ADDR_W-1:2], low};
	endfunction
endpackage

// file: hdl/wmask_fifo_if.sv
// Valid/ready carrier between the beat capture and the write queue
`timescale 1ns/1ps
`default_nettype none
interface wmask_fifo_if #(parameter int W = 8);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport queue (input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// file: hdl/wmask_fifo.sv
// Synchronous FIFO holding masked write beats on their way to the array
`timescale 1ns/1ps
`default_nettype none
module wmask_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic rst,
	wmask_fifo_if.queue f
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic do_push;
	logic do_pop;

	assign f.in_ready = (count != (PW+1)'(D));
	assign f.out_valid = (count != '0);
	assign f.out_data = mem[rd_ptr];
	assign do_push = f.in_valid & f.in_ready;
	assign do_pop = f.out_valid & f.out_ready;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= f.in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	fill_bound_a: assert property (@(posedge clk) disable iff (rst) count <= (PW+1)'(D))
		else $error("fifo count above depth");
endmodule
`default_nettype wire

// file: hdl/sram_wmask.sv
// Burst SRAM write path with per-beat lane write masking
`timescale 1ns/1ps
`default_nettype none
module sram_wmask
	import sram_wmask_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_K,
	input wire logic I_K_N,
	input wire logic I_LOAD_REQUEST_N,
	input wire logic I_READ_NOT_WRITE,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [DATA_W-1:0] I_DATA,
	input wire logic [LANES-1:0] I_LANE_WRITE_SELECT_N,
	input wire logic [1:0] I_ORG,
	input wire logic I_RD_EN,
	input wire logic [ADDR_W-1:0] I_RD_ADDR,
	output logic [DATA_W-1:0] O_RD_DATA,
	output logic O_RD_VALID,
	output logic O_ACCEPT_READY,
	output logic O_OVERFLOW
);
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic k;
	logic k_n;
	logic load_n;
	logic rnw;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	logic [LANES-1:0] sel_n;
	logic [1:0] org_pin;
	logic k_prev;
	logic k_n_prev;
	logic k_rise;
	logic kn_rise;
	logic start;
	org_e org;
	logic org_taken;
	wr_state_e state;
	logic pending;
	logic [ADDR_W-1:0] cmd_addr;
	logic [ADDR_W-1:0] pend_addr;
	logic beat_edge;
	logic [1:0] beat;
	logic [DATA_W-1:0] mask;
	logic push;
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [ADDR_W-1:0] wr_idx;
	logic [DATA_W-1:0] wr_mask;
	logic [DATA_W-1:0] wr_data;
	logic wr_go;
	logic chk_go;
	logic [ADDR_W-1:0] chk_idx;
	logic [DATA_W-1:0] chk_mask;
	logic [DATA_W-1:0] chk_keep;

	wmask_fifo_if #(.W(ENTRY_W)) q ();

	// Pins come from the controller's clock pair, so everything is synchronised first
	// No reset: the strap must already stand at the second flop when reset lifts
	always_ff @(posedge I_CLK) begin
		pin_s1 <= {I_K, I_K_N, I_LOAD_REQUEST_N, I_READ_NOT_WRITE, I_ADDR, I_DATA,
			I_LANE_WRITE_SELECT_N, I_ORG};
		pin_s2 <= pin_s1;
	end
	assign {k, k_n, load_n, rnw, addr, data, sel_n, org_pin} = pin_s2;

	// History follows the pins through reset, so release shows no false edge
	always_ff @(posedge I_CLK) begin
		k_prev <= k;
		k_n_prev <= k_n;
	end
	assign k_rise = k & ~k_prev;
	assign kn_rise = k_n & ~k_n_prev;
	assign start = k_rise & ~load_n & ~rnw;

	// Organisation is a strap, caught once after reset release
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			org <= ORG_RESET;
			org_taken <= 1'b0;
		end else if (!org_taken) begin
			org <= org_e'(org_pin);
			org_taken <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			state <= ST_IDLE;
			pending <= 1'b0;
			cmd_addr <= ADDR_RESET;
			pend_addr <= ADDR_RESET;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_BEAT0;
						cmd_addr <= addr;
					end
				end
				ST_BEAT0: begin
					if (k_rise) begin
						state <= ST_BEAT1;
					end
				end
				ST_BEAT1: begin
					if (kn_rise) begin
						state <= ST_BEAT2;
					end
				end
				ST_BEAT2: begin
					if (k_rise) begin
						state <= ST_BEAT3;
						// Back-to-back write may start on the t+2 edge
						if (start) begin
							pending <= 1'b1;
							pend_addr <= addr;
						end
					end
				end
				ST_BEAT3: begin
					if (kn_rise) begin
						pending <= 1'b0;
						state <= pending ? ST_BEAT0 : ST_IDLE;
						cmd_addr <= pend_addr;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		beat_edge = 1'b0;
		beat = 2'h0;
		case (state)
			ST_BEAT0: begin
				beat_edge = k_rise;
				beat = 2'h0;
			end
			ST_BEAT1: begin
				beat_edge = kn_rise;
				beat = 2'h1;
			end
			ST_BEAT2: begin
				beat_edge = k_rise;
				beat = 2'h2;
			end
			ST_BEAT3: begin
				beat_edge = kn_rise;
				beat = 2'h3;
			end
			default: begin
				beat_edge = 1'b0;
				beat = 2'h0;
			end
		endcase
	end

	// Fresh mask per beat; a fully masked beat is never queued
	assign mask = lane_mask(org, sel_n);
	assign push = beat_edge & (mask != MASK_NONE);
	assign q.in_valid = push;
	assign q.in_data = {burst_index(org, cmd_addr, beat), mask, data};

	// Reads take the array port, so the queue drains only in idle cycles
	assign q.out_ready = ~I_RD_EN;
	assign {wr_idx, wr_mask, wr_data} = q.out_data;
	assign wr_go = q.out_valid & q.out_ready;

	wmask_fifo #(.W(ENTRY_W), .D(FIFO_DEPTH)) u_queue (
		.clk(I_CLK),
		.rst(I_SYS_RST),
		.f(q.queue)
	);

	always_ff @(posedge I_CLK) begin
		if (wr_go) begin
			mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_RD_DATA <= DATA_RESET;
			O_RD_VALID <= 1'b0;
		end else begin
			O_RD_VALID <= I_RD_EN;
			if (I_RD_EN) begin
				O_RD_DATA <= mem[I_RD_ADDR];
			end
		end
	end

	// Pins cannot be stalled, so a beat meeting a full queue is lost and flagged
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_ACCEPT_READY <= 1'b0;
			O_OVERFLOW <= 1'b0;
		end else begin
			O_ACCEPT_READY <= q.in_ready;
			if (push && !q.in_ready) begin
				O_OVERFLOW <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			chk_go <= 1'b0;
			chk_idx <= ADDR_RESET;
			chk_mask <= MASK_NONE;
			chk_keep <= DATA_RESET;
		end else begin
			chk_go <= wr_go;
			chk_idx <= wr_idx;
			chk_mask <= wr_mask;
			chk_keep <= mem[wr_idx] & ~wr_mask;
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	start_to_beat_a: assert property ((state == ST_IDLE && start) |=> state == ST_BEAT0)
		else $error("write start did not arm the first beat");
	beat_sample_a: assert property ((state == ST_BEAT1 && kn_rise && mask != MASK_NONE) |-> push)
		else $error("complement edge beat not sampled");
	no_cmd_write_a: assert property ((state == ST_IDLE) |-> !push)
		else $error("selects acted outside a write");
	nibble_lanes_a: assert property ((push && org == ORG_X8) |->
			q.in_data[2*DATA_W-1:DATA_W] ==
			{28'h000_0000, {NIB_W{~sel_n[1]}}, {NIB_W{~sel_n[0]}}})
		else $error("nibble mask wrong");
	wide_lanes_a: assert property ((push && org == ORG_X36) |->
			q.in_data[DATA_W+LANE_W-1:DATA_W] == {LANE_W{~sel_n[0]}}
			&& q.in_data[2*DATA_W-1:2*DATA_W-LANE_W] == {LANE_W{~sel_n[3]}})
		else $error("lane mask wrong");
	single_lane_a: assert property ((push && org == ORG_X9) |->
			q.in_data[2*DATA_W-1:DATA_W] == {27'h000_0000, 9'h1FF})
		else $error("9-bit word mask wrong");
	all_masked_a: assert property ((beat_edge && &sel_n) |-> !push)
		else $error("fully masked beat was queued");
	// Only lanes of the strapped width are compared; the rest of the array is never written
	keep_lanes_a: assert property (chk_go |->
			((mem[chk_idx] ^ chk_keep) & ~chk_mask & lane_mask(org, '0)) == MASK_NONE)
		else $error("unselected lanes changed");
	burst_done_a: assert property ((state == ST_BEAT3 && kn_rise && !pending) |=> state == ST_IDLE)
		else $error("burst did not end after fourth beat");

	write_start_c: cover property (state == ST_IDLE && start);
	partial_beat_c: cover property (push && !(&(~sel_n)));
	queue_full_c: cover property (!q.in_ready);
	back_to_back_c: cover property (state == ST_BEAT3 && kn_rise && pending);
endmodule
`default_nettype wire

// file: dv/burst_ctrl_model.sv
// Controller model driving the write pins of the burst SRAM
`timescale 1ns/1ps
`default_nettype none
module burst_ctrl_model
	import sram_wmask_pkg::*;
#(
	parameter int HALF = 4
)
(
	input wire logic i_clk,
	output var logic o_k,
	output var logic o_k_n,
	output var logic o_load_n,
	output var logic o_rnw,
	output var logic [ADDR_W-1:0] o_addr,
	output var logic [DATA_W-1:0] o_data,
	output var logic [LANES-1:0] o_sel_n
);
	// Clock pins stand still between bursts
	initial begin
		o_k = 1'b0;
		o_k_n = 1'b1;
		o_load_n = 1'b1;
		o_rnw = 1'b0;
		o_addr = ADDR_RESET;
		o_data = DATA_RESET;
		o_sel_n = 4'hF;
	end
	// Each level held HALF cycles, the pin synchroniser needs two
	task automatic step(input logic k, input logic ld_n, input logic [DATA_W-1:0] d,
			input logic [LANES-1:0] s);
		o_k = k;
		o_k_n = ~k;
		o_load_n = ld_n;
		o_data = d;
		o_sel_n = s;
		repeat (HALF) @(posedge i_clk);
		#1;
	endtask
	task automatic run(input logic rnw, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] w [4], input logic [LANES-1:0] s [4]);
		o_rnw = rnw;
		o_addr = a;
		step(1'b1, 1'b0, ~o_data, 4'h0);
		o_rnw = ~rnw;
		o_addr = ~a;
		// Selects low off the beats, they must not reach the array
		step(1'b0, 1'b1, ~o_data, 4'h0);
		for (int i = 0; i < 4; i++) begin
			step(1'(i % 2 == 0), 1'b1, w[i], s[i]);
		end
		o_data = ~o_data;
	endtask
endmodule
`default_nettype wire

// file: dv/sram_wmask_bench.sv
// Self-checking bench for the burst SRAM write masking block
`timescale 1ns/1ps
`default_nettype none
module sram_wmask_bench;
	import sram_wmask_pkg::*;
	localparam int TIMEOUT = 5000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] org = 2'h3;
	logic rd_en = 1'b0;
	logic [ADDR_W-1:0] rd_addr = ADDR_RESET;
	logic k, k_n, load_n, rnw;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data, rd_data;
	logic [LANES-1:0] sel_n;
	logic rd_valid, acc_ready, ovf;
	logic [DATA_W-1:0] shadow [MEM_DEPTH];
	logic [DATA_W-1:0] fill [4] = '{36'h1_2345_6789, 36'hA_BCDE_F012, 36'h5_5AA5_C33C,
		36'hF_0F0F_0F0F};
	logic [DATA_W-1:0] word [4] = '{36'h9_8765_4321, 36'h3_C3C3_C3C3, 36'h6_9966_9966,
		36'hE_DCBA_0987};
	int error_cnt = 0;
	int n_tests = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	burst_ctrl_model ctrl (.i_clk(clk), .o_k(k), .o_k_n(k_n), .o_load_n(load_n), .o_rnw(rnw),
		.o_addr(addr), .o_data(data), .o_sel_n(sel_n));
	sram_wmask dut (.I_CLK(clk), .I_SYS_RST(rst), .I_K(k), .I_K_N(k_n),
		.I_LOAD_REQUEST_N(load_n), .I_READ_NOT_WRITE(rnw), .I_ADDR(addr), .I_DATA(data),
		.I_LANE_WRITE_SELECT_N(sel_n), .I_ORG(org), .I_RD_EN(rd_en), .I_RD_ADDR(rd_addr),
		.O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_ACCEPT_READY(acc_ready),
		.O_OVERFLOW(ovf));
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			error_cnt++;
			finish_test();
		end
	end
	// Bits written per organisation, worked out lane by lane
	function automatic logic [DATA_W-1:0] lane_bits(input logic [1:0] o, input logic [3:0] s);
		case (o)
			2'h0: return {28'h0, {4{~s[1]}}, {4{~s[0]}}};
			2'h1: return {27'h0, {9{~s[0]}}};
			2'h2: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
			default: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
		endcase
	endfunction
	function automatic logic [ADDR_W-1:0] slot(input logic [1:0] o, input logic [ADDR_W-1:0] a,
			input int n);
		logic [1:0] low;
		low = (o < 2'h2) ? 2'(n) : a[1:0] + 2'(n);
		return {a[ADDR_W-1:2], low};
	endfunction
	task automatic burst(input logic [1:0] o, input logic r, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] w [4], input logic [LANES-1:0] s [4]);
		logic [DATA_W-1:0] m;
		logic [ADDR_W-1:0] i;
		ctrl.run(r, a, w, s);
		for (int n = 0; n < 4; n++) begin
			m = r ? 36'h0_0000_0000 : lane_bits(o, s[n]);
			i = slot(o, a, n);
			shadow[i] = (shadow[i] & ~m) | (w[n] & m);
		end
		// Let the queue drain into the array
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic verify(input logic [1:0] o, input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] wm;
		wm = lane_bits(o, 4'h0);
		rd_en = 1'b1;
		for (int n = 0; n < 4; n++) begin
			rd_addr = slot(o, a, n);
			@(posedge clk);
			#1;
			check(rd_data & wm, shadow[rd_addr] & wm);
			check(DATA_W'(rd_valid), 36'h1);
		end
		rd_en = 1'b0;
		@(posedge clk);
		#1;
		check(DATA_W'(rd_valid), 36'h0);
	endtask
	// Strap only taken at reset, so each organisation gets a fresh one
	task automatic org_case(input logic [1:0] o, input logic [ADDR_W-1:0] a,
			input logic [LANES-1:0] s [4]);
		rst = 1'b1;
		org = o;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		burst(o, 1'b0, a, fill, '{4'h0, 4'h0, 4'h0, 4'h0});
		burst(o, 1'b0, a, word, s);
		verify(o, a);
		// A read command with selects low must leave the array alone
		burst(o, 1'b1, a, fill, '{4'h0, 4'h0, 4'h0, 4'h0});
		verify(o, a);
		check(DATA_W'(acc_ready), 36'h1);
		check(DATA_W'(ovf), 36'h0);
		$display("org %0d done", o);
	endtask
	// Reads hold the array port, so twenty queued beats overrun the sixteen entries
	task automatic test_overflow;
		rd_en = 1'b1;
		repeat (5) ctrl.run(1'b0, 6'h30, word, '{4'h0, 4'h0, 4'h0, 4'h0});
		check(DATA_W'(ovf), 36'h1);
		check(DATA_W'(acc_ready), 36'h0);
		rd_en = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		check(DATA_W'(acc_ready), 36'h1);
		check(DATA_W'(ovf), 36'h1);
		$display("overflow done");
	endtask
	task automatic test_wide_lanes;
		org_case(2'h3, 6'h0E, '{4'hE, 4'h5, 4'hF, 4'h7});
	endtask
	task automatic test_half_lanes;
		org_case(2'h2, 6'h21, '{4'h1, 4'h2, 4'h3, 4'h4});
	endtask
	task automatic test_nibbles;
		org_case(2'h0, 6'h17, '{4'h1, 4'h2, 4'h3, 4'h4});
	endtask
	task automatic test_single_lane;
		org_case(2'h1, 6'h3B, '{4'hE, 4'h1, 4'h0, 4'hF});
	endtask
	initial begin
		test_wide_lanes();
		test_half_lanes();
		test_nibbles();
		test_single_lane();
		test_overflow();
		finish_test();
	end
endmodule
`default_nettype wire
